// ==== design/ssp_pipe_ctrl.sv ====
/*
 stage sequencing and routing for the dual issue core:
 address select, queue, register fetch and the per pipe
 execute, data fetch, write-back and float stages.
 assumes caches, translation buffers, register files and
 execution units sit outside on the same clock and answer
 within the stage that asks them.
*/
`timescale 1ns/1ns
`include "ssp_consts.svh"
module ssp_pipe_ctrl (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // queue stage answers
    input wire logic i_tag_hit,
    input wire logic [1:0] i_steer,
    input wire ssp_pkg::ssp_slot_t i_slot0,
    input wire ssp_pkg::ssp_slot_t i_slot1,
    // register fetch dependency checks
    input wire logic [1:0] i_dep,
    // redirect sources
    input wire logic i_br_redirect,
    input wire logic [31:0] i_br_target,
    input wire logic i_pred_hit,
    input wire logic [31:0] i_pred_target,
    input wire logic i_eret,
    input wire logic [31:0] i_ret_addr,
    input wire logic [31:0] i_vector,
    // exceptions seen in data fetch, per pipe
    input wire ssp_pkg::ssp_pmask_t i_exc_d,
    // fetch side
    output ssp_pkg::ssp_fsel_t o_fetch_sel,
    output logic [31:0] o_fetch_addr,
    output logic o_q_lookup,
    output logic o_phase,
    output logic o_hold,
    // issue and stages
    output ssp_pkg::ssp_pmask_t o_route0,
    output ssp_pkg::ssp_pmask_t o_route1,
    output ssp_pkg::ssp_stage_t o_stage,
    output logic o_fp_bypass,
    output logic o_hist_upd,
    output logic o_flush
);
    import ssp_pkg::*;

    // physical pipes for one category, alu side chosen by caller
    function automatic ssp_pmask_t route(input ssp_cat_t c, input logic alu_b);
        ssp_pmask_t m;
        m = '0;
        case (c)
            SSP_CAT_MEM, SSP_CAT_SYS: m[`SSP_MEMP] = 1'b1;
            SSP_CAT_SYNC, SSP_CAT_ERET, SSP_CAT_MACS: m[`SSP_IB] = 1'b1;
            SSP_CAT_SHAMT, SSP_CAT_MACP: m[`SSP_IA] = 1'b1;
            SSP_CAT_FMOV:
            begin
                m[`SSP_MEMP] = 1'b1;
                m[`SSP_FP] = 1'b1;
            end
            SSP_CAT_FOP:
            begin
                m[`SSP_IA] = 1'b1;
                m[`SSP_FP] = 1'b1;
            end
            SSP_CAT_ALU:
            begin
                if (alu_b)
                    m[`SSP_IB] = 1'b1;
                else
                    m[`SSP_IA] = 1'b1;
            end
            SSP_CAT_BRANCH: m[`SSP_BRANCH] = 1'b1;
            SSP_CAT_WIDE:
            begin
                m[`SSP_IA] = 1'b1;
                m[`SSP_IB] = 1'b1;
            end
            default: m = '0;
        endcase
        return m;
    endfunction : route

    // phase flop; a stage spans two clocks, advance on the second
    logic ph;
    // current fetch address and source
    logic [31:0] pc;
    ssp_fsel_t fsel;
    // queue stage occupancy
    logic q_vld;
    // staging slots in register fetch
    ssp_slot_t r0;
    ssp_slot_t r1;
    // execute, data fetch, write-back occupancy
    ssp_pmask_t a_vld;
    ssp_pmask_t d_vld;
    ssp_pmask_t w_vld;
    // float stages t, x, y, z, s
    logic [4:0] fp_vld;
    // registered strobes
    logic hold;
    logic hist_upd;
    logic fp_byp;
    logic flush;
    ssp_pmask_t rt0;
    ssp_pmask_t rt1;

    // stage enable, one pulse per two clocks
    wire stg_en = ph;

    // register fetch decode and hazard checks
    wire ssp_pmask_t m0 = r0.vld ? route(r0.cat, 1'b0) : '0;
    wire alu_b1 = m0[`SSP_IA];
    wire ssp_pmask_t m1 = r1.vld ? route(r1.cat, alu_b1) : '0;
    wire conflict = |(m0 & m1); // structural hazard
    // an exception in data fetch squashes every younger stage
    wire exc_now = |(d_vld & i_exc_d);
    wire iss0 = r0.vld & ~i_dep[0] & ~exc_now;
    wire iss1 = r1.vld & (iss0 | ~r0.vld) & ~i_dep[1] & ~conflict & ~exc_now;
    wire ssp_pmask_t next_a = (iss0 ? m0 : '0) | (iss1 ? m1 : '0);
    // leftover slot keeps the front end frozen
    wire next_hold = ~exc_now & ((r0.vld & ~iss0) | (r1.vld & ~iss1));

    // fetch address select, exception vector first
    wire [31:0] seq_addr = pc + `SSP_SEQ_STEP;
    wire ssp_fsel_t next_fsel = exc_now ? SSP_SEL_VECTOR :
                                i_eret ? SSP_SEL_RETURN :
                                i_br_redirect ? SSP_SEL_BRANCH :
                                i_pred_hit ? SSP_SEL_PRED : SSP_SEL_SEQ;
    wire [31:0] next_pc = (next_fsel == SSP_SEL_VECTOR) ? i_vector :
                          (next_fsel == SSP_SEL_RETURN) ? i_ret_addr :
                          (next_fsel == SSP_SEL_BRANCH) ? i_br_target :
                          (next_fsel == SSP_SEL_PRED) ? i_pred_target : seq_addr;
    wire redirect = exc_now | i_eret | i_br_redirect;
    // slots leave queue only on a tag hit, chosen by steering
    wire q_take = q_vld & i_tag_hit & ~redirect;
    wire ssp_slot_t q0 = '{vld: q_take & i_steer[0], cat: i_slot0.cat};
    wire ssp_slot_t q1 = '{vld: q_take & i_steer[1], cat: i_slot1.cat};

    // phase toggle
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
            ph <= 1'b0;
        else
            ph <= ~ph;
    end

    // address select and queue stages
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pc <= `SSP_RESET_PC;
            fsel <= SSP_SEL_SEQ;
            q_vld <= 1'b0;
        end
        else if (stg_en && (redirect || !next_hold))
        begin
            // a redirect overrides a hold so the vector is not lost
            pc <= next_pc;
            fsel <= next_fsel;
            q_vld <= ~redirect;
        end
    end

    // register fetch staging slots
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            r0 <= '0;
            r1 <= '0;
        end
        else if (stg_en)
        begin
            if (redirect)
            begin
                // wrong path or excepted, drop both
                r0 <= '0;
                r1 <= '0;
            end
            else if (next_hold && iss0)
            begin
                // older went, younger waits alone
                r0 <= r1;
                r1 <= '0;
            end
            else if (!next_hold)
            begin
                r0 <= q0;
                r1 <= q1;
            end
        end
    end

    // execution pipes a, d, w; exceptions kill d before commit
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            a_vld <= '0;
            d_vld <= '0;
            w_vld <= '0;
            hist_upd <= 1'b0;
        end
        else if (stg_en)
        begin
            a_vld <= next_a;
            d_vld <= exc_now ? '0 : a_vld;
            w_vld <= exc_now ? '0 : d_vld;
            hist_upd <= ~exc_now & a_vld[`SSP_BRANCH];
        end
    end

    // float stages; t runs beside a, x beside d, y beside w
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            fp_vld <= '0;
            fp_byp <= 1'b0;
        end
        else if (stg_en)
        begin
            fp_vld[`SSP_FT] <= next_a[`SSP_FP];
            fp_vld[`SSP_FX] <= ~exc_now & fp_vld[`SSP_FT];
            fp_vld[`SSP_FY] <= ~exc_now & fp_vld[`SSP_FX];
            fp_vld[`SSP_FZ] <= fp_vld[`SSP_FY];
            fp_vld[`SSP_FS] <= fp_vld[`SSP_FZ];
            // s feeds t when both are occupied next stage
            fp_byp <= next_a[`SSP_FP] & fp_vld[`SSP_FZ];
        end
    end

    // issue route, hold and flush strobes
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            hold <= 1'b0;
            flush <= 1'b0;
            rt0 <= '0;
            rt1 <= '0;
        end
        else if (stg_en)
        begin
            hold <= next_hold;
            flush <= exc_now;
            rt0 <= iss0 ? m0 : '0;
            rt1 <= iss1 ? m1 : '0;
        end
    end

    // outputs come straight from the flops above
    assign o_phase = ph;
    assign o_fetch_addr = pc;
    assign o_fetch_sel = fsel;
    assign o_q_lookup = q_vld;
    assign o_hold = hold;
    assign o_route0 = rt0;
    assign o_route1 = rt1;
    assign o_stage = '{a: a_vld, d: d_vld, w: w_vld, fp: fp_vld};
    assign o_fp_bypass = fp_byp;
    assign o_hist_upd = hist_upd;
    assign o_flush = flush;

    // checks on stage flow, one stage equals two clocks
    AST_PHASE: assert property (@(posedge i_clk) disable iff (i_reset)
        ph |=> !ph)
        else $error("phase did not alternate");
    AST_D_FOLLOWS_A: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && !exc_now) |=> (d_vld == $past(a_vld)))
        else $error("data fetch did not follow execute");
    AST_NO_COMMIT_AFTER_EXC: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && exc_now) |=> (w_vld == '0) ##1 (w_vld == '0))
        else $error("result committed after exception");
    AST_VECTOR_SEL: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && exc_now) |=> (fsel == SSP_SEL_VECTOR && pc == $past(i_vector)))
        else $error("exception vector not selected");
    AST_HIST_IN_D: assert property (@(posedge i_clk) disable iff (i_reset)
        hist_upd |-> d_vld[`SSP_BRANCH])
        else $error("history update outside data fetch");
    AST_WIDE_BOTH: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && r0.cat == SSP_CAT_WIDE) |=> (rt0[`SSP_IA] && rt0[`SSP_IB]))
        else $error("wide op not on both integer pipes");
    AST_FP_WITH_A: assert property (@(posedge i_clk) disable iff (i_reset)
        fp_vld[`SSP_FT] |-> (a_vld[`SSP_IA] || a_vld[`SSP_MEMP]))
        else $error("float stage without integer partner");
    AST_NO_DOUBLE_USE: assert property (@(posedge i_clk) disable iff (i_reset)
        !(|(rt0 & rt1)))
        else $error("two instructions on one pipe");
    AST_HOLD_BUBBLE: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && r0.vld && i_dep[0] && !exc_now) |=> (hold && rt0 == '0 && rt1 == '0))
        else $error("dependent instruction issued");
    AST_FP_CHAIN: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && fp_vld[`SSP_FY]) |=> ##1 fp_vld[`SSP_FZ] ##2 fp_vld[`SSP_FS])
        else $error("float stages did not advance");
    AST_BR_PIPE: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && r0.cat == SSP_CAT_BRANCH) |=> (rt0 == (ssp_pmask_t'(1) << `SSP_BRANCH)))
        else $error("branch not on branch pipe");

    // fixed category policies; the single-pipe ones must land on exactly their own pipes
    // memory and system ops use the load/store pipe alone
    AST_MEM_PIPE: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && (r0.cat == SSP_CAT_MEM || r0.cat == SSP_CAT_SYS))
        |=> (rt0 == (ssp_pmask_t'(1) << `SSP_MEMP)))
        else $error("memory op not on load store pipe");
    // shift amount and primary mac stay on pipe a
    AST_PRIMARY_A: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && (r0.cat == SSP_CAT_SHAMT || r0.cat == SSP_CAT_MACP))
        |=> (rt0 == (ssp_pmask_t'(1) << `SSP_IA)))
        else $error("primary op not on pipe a");
    // secondary mac owns the second high/low pair, so pipe b only
    AST_SECONDARY_B: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && r0.cat == SSP_CAT_MACS) |=> (rt0 == (ssp_pmask_t'(1) << `SSP_IB)))
        else $error("secondary mac not on pipe b");
    // float moves pair load/store with the float pipe
    AST_FMOV_PAIR: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && r0.cat == SSP_CAT_FMOV) |=> (rt0[`SSP_MEMP] && rt0[`SSP_FP] && !rt0[`SSP_IA]))
        else $error("float move not on load store and float pipes");
    // float operates pair pipe a with the float pipe
    AST_FOP_PAIR: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && r0.cat == SSP_CAT_FOP) |=> (rt0[`SSP_IA] && rt0[`SSP_FP] && !rt0[`SSP_MEMP]))
        else $error("float operate not on pipe a and float pipe");
    // two alu ops together must split over both integer pipes
    AST_ALU_SPLIT: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && iss0 && iss1 && r0.cat == SSP_CAT_ALU && r1.cat == SSP_CAT_ALU) |=> (rt0[`SSP_IA] && rt1[`SSP_IB]))
        else $error("alu pair not split over integer pipes");

    // front end and flush checks
    // plain sequential fetch steps by one pair
    AST_SEQ_STEP: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && !next_hold && next_fsel == SSP_SEL_SEQ) |=> (pc == $past(pc) + `SSP_SEQ_STEP))
        else $error("sequential fetch did not step");
    // a hold freezes address and queue so nothing is skipped
    AST_FETCH_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && next_hold && !redirect) |=> (pc == $past(pc) && q_vld == $past(q_vld)))
        else $error("fetch moved during hold");
    // wrong path fetch must not reach register fetch
    AST_Q_DROP: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && redirect) |=> !q_vld)
        else $error("queue kept after redirect");
    // flush strobe and empty younger stages after an exception
    AST_FLUSH_STROBE: assert property (@(posedge i_clk) disable iff (i_reset)
        (ph && exc_now) |=> (flush && d_vld == '0 && !r0.vld && !r1.vld))
        else $error("exception did not flush");
    COV_DUAL: cover property (@(posedge i_clk) disable iff (i_reset)
        ph && iss0 && iss1);
    COV_CONFLICT: cover property (@(posedge i_clk) disable iff (i_reset)
        ph && conflict && iss0);
    COV_EXC: cover property (@(posedge i_clk) disable iff (i_reset)
        ph && exc_now);
    COV_BYPASS: cover property (@(posedge i_clk) disable iff (i_reset)
        fp_byp);
    // a dependency or pipe conflict really stalled register fetch
    COV_HOLD: cover property (@(posedge i_clk) disable iff (i_reset)
        ph && next_hold);
endmodule : ssp_pipe_ctrl

// ==== design/ssp_consts.svh ====
/*
 holds the numeric constants of the pipe stage routing block.
 assumes inclusion by bare name from the package and the module.
*/
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH
// bit positions of the physical pipe mask
`define SSP_IA 0
`define SSP_IB 1
`define SSP_MEMP 2
`define SSP_BRANCH 3
`define SSP_FP 4
`define SSP_NPIPE 5
// floating point stage positions after register fetch
`define SSP_FT 0
`define SSP_FX 1
`define SSP_FY 2
`define SSP_FZ 3
`define SSP_FS 4
// address step for one fetched pair of 32-bit words
`define SSP_SEQ_STEP 32'h0000_0008
// fetch address after reset
`define SSP_RESET_PC 32'h0000_0000
`endif

// ==== design/ssp_pkg.sv ====
/*
 holds the types shared by the pipe stage routing block.
 assumes ssp_consts.svh is on the include path.
*/
`include "ssp_consts.svh"
package ssp_pkg;
    // instruction categories, one issue policy each
    typedef enum logic [3:0] {
        SSP_CAT_MEM = 4'h0,
        SSP_CAT_SYNC = 4'h1,
        SSP_CAT_ERET = 4'h2,
        SSP_CAT_SHAMT = 4'h3,
        SSP_CAT_SYS = 4'h4,
        SSP_CAT_FMOV = 4'h5,
        SSP_CAT_FOP = 4'h6,
        SSP_CAT_ALU = 4'h7,
        SSP_CAT_MACP = 4'h8,
        SSP_CAT_MACS = 4'h9,
        SSP_CAT_BRANCH = 4'ha,
        SSP_CAT_WIDE = 4'hb
    } ssp_cat_t;
    // fetch address sources
    typedef enum logic [2:0] {
        SSP_SEL_SEQ = 3'h0,
        SSP_SEL_BRANCH = 3'h1,
        SSP_SEL_PRED = 3'h2,
        SSP_SEL_VECTOR = 3'h3,
        SSP_SEL_RETURN = 3'h4
    } ssp_fsel_t;
    // one physical pipe per bit
    typedef logic [`SSP_NPIPE-1:0] ssp_pmask_t;
    // one instruction slot
    typedef struct packed {
        logic vld;
        ssp_cat_t cat;
    } ssp_slot_t;
    // stage occupancy of the execution pipes
    typedef struct packed {
        ssp_pmask_t a;
        ssp_pmask_t d;
        ssp_pmask_t w;
        logic [4:0] fp;
    } ssp_stage_t;
endpackage : ssp_pkg

// ==== bench/ssp_fetch_model.sv ====
/*
 model of the fetch side: cache, steering bits and tag hit.
 assumes the bench pulses i_offer for one clock per fetched pair.
*/
`timescale 1ns/1ns
module ssp_fetch_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // bench side
    input wire logic i_offer,
    input wire ssp_pkg::ssp_cat_t i_cat0,
    input wire ssp_pkg::ssp_cat_t i_cat1,
    input wire logic [1:0] i_want,
    // core side
    input wire logic i_q_lookup,
    input wire logic i_phase,
    output logic o_tag_hit,
    output logic [1:0] o_steer,
    output ssp_pkg::ssp_slot_t o_slot0,
    output ssp_pkg::ssp_slot_t o_slot1
);
    import ssp_pkg::*;
    logic pend; // a pair waits for the queue stage
    logic flip; // idle slots change every clock
    logic [1:0] want; // slots that hold instructions
    ssp_slot_t s0, s1; // the offered pair
    // keep the pair until a stage edge with a lookup takes it
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            pend <= 1'b0;
            flip <= 1'b0;
            want <= 2'h0;
            s0 <= '0;
            s1 <= '0;
        end
        else
        begin
            flip <= ~flip;
            if (i_offer)
            begin
                pend <= 1'b1;
                want <= i_want;
                s0 <= {1'b1, i_cat0};
                s1 <= {1'b1, i_cat1};
            end
            else if (pend && i_phase && i_q_lookup)
                pend <= 1'b0;
        end
    end
    // hit and steering only while a pair is really there
    assign o_tag_hit = pend && i_q_lookup;
    assign o_steer = pend ? want : 2'h0;
    // stale slots are inverted every other clock, so a missed gate cannot pass
    assign o_slot0 = (pend || !flip) ? s0 : ssp_slot_t'(~s0);
    assign o_slot1 = (pend || !flip) ? s1 : ssp_slot_t'(~s1);
endmodule : ssp_fetch_model

// ==== bench/superscalar_pipe_stage_routing_bench.sv ====
/*
 self-checking bench for the pipe stage routing block.
 assumes the fetch model stands in for cache and steering.
*/
`timescale 1ns/1ns
module superscalar_pipe_stage_routing_bench;
    import ssp_pkg::*;
    // stimulus
    logic i_clk = 1'b0, i_reset = 1'b1, i_offer = 1'b0;
    logic i_br_redirect = 1'b0, i_pred_hit = 1'b0, i_eret = 1'b0;
    logic [1:0] i_dep = 2'h0, want = 2'h0;
    logic [31:0] i_br_target = 32'h0000_1000, i_pred_target = 32'h0000_2000;
    logic [31:0] i_ret_addr = 32'h0000_3000, i_vector = 32'h0000_0080;
    ssp_pmask_t i_exc_d = 5'h00;
    ssp_cat_t cat0 = SSP_CAT_MEM, cat1 = SSP_CAT_MEM;
    // model answers and core outputs
    logic tag_hit, o_q_lookup, o_phase, o_hold, o_fp_bypass, o_hist_upd, o_flush;
    logic [1:0] steer;
    ssp_slot_t slot0, slot1;
    ssp_fsel_t o_fetch_sel;
    logic [31:0] o_fetch_addr;
    ssp_pmask_t o_route0, o_route1;
    ssp_stage_t o_stage;
    int n_mismatch = 0, comparisons = 0;

    ssp_pipe_ctrl i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_tag_hit(tag_hit), .i_steer(steer),
        .i_slot0(slot0), .i_slot1(slot1), .i_dep(i_dep), .i_br_redirect(i_br_redirect),
        .i_br_target(i_br_target), .i_pred_hit(i_pred_hit), .i_pred_target(i_pred_target),
        .i_eret(i_eret), .i_ret_addr(i_ret_addr), .i_vector(i_vector), .i_exc_d(i_exc_d),
        .o_fetch_sel(o_fetch_sel), .o_fetch_addr(o_fetch_addr), .o_q_lookup(o_q_lookup),
        .o_phase(o_phase), .o_hold(o_hold), .o_route0(o_route0), .o_route1(o_route1),
        .o_stage(o_stage), .o_fp_bypass(o_fp_bypass), .o_hist_upd(o_hist_upd), .o_flush(o_flush));
    ssp_fetch_model i_fetch (.i_clk(i_clk), .i_reset(i_reset), .i_offer(i_offer), .i_cat0(cat0),
        .i_cat1(cat1), .i_want(want), .i_q_lookup(o_q_lookup), .i_phase(o_phase),
        .o_tag_hit(tag_hit), .o_steer(steer), .o_slot0(slot0), .o_slot1(slot1));

    // 10 MHz clock
    always #50 i_clk = ~i_clk;

    // inputs move just after each rising edge
    task automatic step;
        @(posedge i_clk);
        #1;
    endtask : step

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    // hand one fetched pair to the model
    task automatic offer(input ssp_cat_t a, input ssp_cat_t b, input logic [1:0] s);
        cat0 = a;
        cat1 = b;
        want = s;
        i_offer = 1'b1;
        step;
        i_offer = 1'b0;
    endtask : offer

    // physical pipes that each category must occupy
    function automatic ssp_pmask_t pipes(input ssp_cat_t c);
        case (c)
            SSP_CAT_MEM, SSP_CAT_SYS: pipes = 5'h04;
            SSP_CAT_SYNC, SSP_CAT_ERET, SSP_CAT_MACS: pipes = 5'h02;
            SSP_CAT_SHAMT, SSP_CAT_MACP, SSP_CAT_ALU: pipes = 5'h01;
            SSP_CAT_FMOV: pipes = 5'h14;
            SSP_CAT_FOP: pipes = 5'h11;
            SSP_CAT_BRANCH: pipes = 5'h08;
            default: pipes = 5'h03;
        endcase
    endfunction : pipes

    // one instruction walks a, d and w of its pipes
    task automatic route_one(input ssp_cat_t c);
        ssp_pmask_t e;
        int i;
        e = pipes(c);
        offer(c, c, 2'b01);
        for (i = 0; i < 20 && o_route0 === 5'h00; i++)
            step;
        check("route0", 32'(o_route0), 32'(e));
        check("a mask", 32'(o_stage.a), 32'(e));
        if (c == SSP_CAT_FOP)
            check("fp t", 32'(o_stage.fp[0]), 32'h1);
        step;
        step;
        check("d mask", 32'(o_stage.d), 32'(e));
        check("hist upd", 32'(o_hist_upd), 32'(e[3]));
        if (c == SSP_CAT_FOP)
            check("fp x", 32'(o_stage.fp[1]), 32'h1);
        step;
        step;
        check("w mask", 32'(o_stage.w), 32'(e));
        if (c == SSP_CAT_FOP)
            check("fp y", 32'(o_stage.fp[2]), 32'h1);
        repeat (6) step;
    endtask : route_one

    // two alu ops issue together, one per integer pipe
    task automatic alu_pair;
        int i;
        offer(SSP_CAT_ALU, SSP_CAT_ALU, 2'b11);
        for (i = 0; i < 20 && o_route0 === 5'h00; i++)
            step;
        check("route0", 32'(o_route0), 32'h01);
        check("route1", 32'(o_route1), 32'h02);
        check("a mask", 32'(o_stage.a), 32'h03);
        repeat (8) step;
    endtask : alu_pair

    // a float op entering t as the previous one leaves z gets the bypass
    task automatic fp_bypass;
        int i;
        offer(SSP_CAT_FOP, SSP_CAT_FOP, 2'b01);
        for (i = 0; i < 20 && o_route0 === 5'h00; i++)
            step;
        repeat (4) step;
        offer(SSP_CAT_FOP, SSP_CAT_FOP, 2'b01);
        for (i = 0; i < 20 && o_route0 === 5'h00; i++)
            step;
        check("fp bypass", 32'(o_fp_bypass), 32'h1);
        check("fp stages", 32'(o_stage.fp), 32'h11);
        step;
        step;
        check("fp bypass", 32'(o_fp_bypass), 32'h0);
        repeat (8) step;
    endtask : fp_bypass

    // a fault in data fetch squashes before commit
    task automatic exc_flush;
        int i;
        offer(SSP_CAT_MEM, SSP_CAT_MEM, 2'b01);
        for (i = 0; i < 20 && o_stage.d === 5'h00; i++)
            step;
        i_exc_d = 5'h04;
        step;
        step;
        i_exc_d = 5'h00;
        for (i = 0; i < 4 && o_flush !== 1'b1; i++)
            step;
        check("flush", 32'(o_flush), 32'h1);
        check("w mask", 32'(o_stage.w), 32'h0);
        check("fetch sel", 32'(o_fetch_sel), 32'(SSP_SEL_VECTOR));
        check("fetch addr", o_fetch_addr, i_vector);
        check("q lookup", 32'(o_q_lookup), 32'h0);
        repeat (8) step;
    endtask : exc_flush

    // redirect sources and their priority
    task automatic redirect(input logic br, input logic pr, input logic er, input ssp_fsel_t s,
        input logic [31:0] a);
        int i;
        i_br_redirect = br;
        i_pred_hit = pr;
        i_eret = er;
        for (i = 0; i < 6 && o_fetch_sel !== s; i++)
            step;
        check("fetch sel", 32'(o_fetch_sel), 32'(s));
        check("fetch addr", o_fetch_addr, a);
        i_br_redirect = 1'b0;
        i_pred_hit = 1'b0;
        i_eret = 1'b0;
        repeat (4) step;
    endtask : redirect

    // sequential fetch steps one pair per stage
    task automatic sequential;
        logic [31:0] a0;
        logic p;
        a0 = o_fetch_addr;
        p = o_phase;
        step;
        check("phase", 32'(o_phase), 32'(!p));
        step;
        check("seq addr", o_fetch_addr, a0 + 32'h0000_0008);
        check("fetch sel", 32'(o_fetch_sel), 32'(SSP_SEL_SEQ));
    endtask : sequential

    // a dependency holds the op, then it issues
    task automatic hazard;
        int i;
        i_dep = 2'b01;
        offer(SSP_CAT_ALU, SSP_CAT_ALU, 2'b01);
        for (i = 0; i < 20 && o_hold !== 1'b1; i++)
            step;
        check("hold", 32'(o_hold), 32'h1);
        check("route0", 32'(o_route0), 32'h0);
        i_dep = 2'b00;
        for (i = 0; i < 8 && o_route0 === 5'h00; i++)
            step;
        check("route0", 32'(o_route0), 32'h01);
        repeat (8) step;
    endtask : hazard

    // cut a hang short
    initial
    begin
        #(100 * 5000);
        n_mismatch++;
        end_sim;
    end

    // main sequence
    initial
    begin
        repeat (3) @(posedge i_clk);
        #1;
        i_reset = 1'b0;
        step;
        step;
        for (int c = 0; c < 12; c++)
            route_one(ssp_cat_t'(4'(c)));
        alu_pair;
        fp_bypass;
        hazard;
        sequential;
        redirect(1'b0, 1'b1, 1'b0, SSP_SEL_PRED, i_pred_target);
        redirect(1'b1, 1'b1, 1'b0, SSP_SEL_BRANCH, i_br_target);
        redirect(1'b1, 1'b1, 1'b1, SSP_SEL_RETURN, i_ret_addr);
        exc_flush;
        end_sim;
    end
endmodule : superscalar_pipe_stage_routing_bench
